/* core/swpmc_pkg.sv */
// Shared constants and types of the switch power mode controller
package swpmc_pkg;

	// Clock and timing figures
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned ED_PULSE_WIDTH_NS = 120;
	localparam int unsigned ED_PULSE_CYC = (ED_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ED_PULSE_PERIOD_NS = 1_000_000_000;
	localparam int unsigned ED_PULSE_PERIOD_CYC = ED_PULSE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned SLEEP_UNIT_NS = 1_000_000;
	localparam int unsigned SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;

	// Geometry
	localparam int unsigned NPHY = 2;
	localparam int unsigned ADDR_W = 8;

	// Register word indexes; byte address is four times the index
	localparam logic [5:0] IDX_MODE = 6'h0e;
	localparam logic [5:0] IDX_SLEEP = 6'h0f;
	localparam logic [5:0] IDX_PCTL0 = 6'h10;
	localparam logic [5:0] IDX_PCTL1 = 6'h11;
	localparam logic [5:0] IDX_PHYC0 = 6'h12;
	localparam logic [5:0] IDX_PHYC1 = 6'h13;
	localparam logic [5:0] IDX_STATUS = 6'h14;

	// Field positions
	localparam int unsigned MODE_LSB = 3;
	localparam int unsigned PCTL_PD_BIT = 3;
	localparam int unsigned PHYC_PD_BIT = 11;

	// Mode encodings and reset values
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ENERGY = 2'h1;
	localparam logic [1:0] MODE_SOFTPD = 2'h2;
	localparam logic [1:0] MODE_SAVING = 2'h3;
	localparam logic [7:0] SLEEP_RST = 8'h50;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Controller states
	typedef enum logic [2:0] {ST_NORMAL, ST_ED_AWAKE, ST_ED_LOW, ST_SOFT_PD, ST_SAVE} swpmc_state_t;

	// Power enables for the gated blocks
	typedef struct packed {
		logic pll_en;
		logic mac_en;
		logic host_en;
		logic [NPHY-1:0] phy_tx_en;
		logic [NPHY-1:0] phy_rx_en;
		logic [NPHY-1:0] phy_ed_en;
	} swpmc_pwr_t;

endpackage : swpmc_pkg

/* core/swpmc_pulse_gen.sv */
// Periodic tick and fixed-width pulse generator
`timescale 1ns/1ns
module swpmc_pulse_gen #(
	parameter int unsigned PERIOD = 16,
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	output logic tick,
	output logic pulse
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic wrap;

	// Restart from zero whenever disabled so a pulse opens each enable
	assign wrap = (cnt_q == 32'(PERIOD - 1));
	assign cnt_d = (!en || wrap) ? 32'h0 : cnt_q + 32'h1;
	assign tick = en && wrap;
	assign pulse = en && (cnt_q < 32'(WIDTH));

	// Free counter, one period long
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : swpmc_pulse_gen

/* core/swpmc_top.sv */
// Power mode controller with AXI4-Lite register access
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Function
// - Mode field resets to normal after power-up or hardware reset.
// - Normal mode keeps PLL, PHYs, MACs and host interface enabled.
// - From normal mode a host write selects any other mode.
// - Writing 01 enters energy detect mode.
// - Energy detect: no energy longer than sleep setting enters low power.
// - Low power disables everything except the receive energy detector.
// - Low power emits 120 ns pulses once per second.
// - Energy seen in low power returns to normal power state.
// - Writing 10 enters soft power-down.
// - Soft power-down stops PLL clocks, PHYs and MACs.
// - Host access in soft power-down wakes to normal and resets registers.
// - Writing 11 with autonegotiation on and no cable enters power saving.
// - Power saving keeps PLL, MAC, registers and host interface alive.
// - Power saving keeps transmitters on, powers down idle receivers.
// - Power saving restores receiver power when line activity appears.
// - From power saving a host write selects any other mode.
// - Port control bit 3 or PHY control bit 11 powers that PHY down.
module swpmc_top #(
	parameter int unsigned PULSE_PERIOD_CYC = swpmc_pkg::ED_PULSE_PERIOD_CYC,
	parameter int unsigned SLEEP_TICK_CYC = swpmc_pkg::SLEEP_UNIT_CYC
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic [swpmc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [swpmc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [swpmc_pkg::NPHY-1:0] LINE_ENERGY,
	input wire logic AUTONEG_EN,
	output swpmc_pkg::swpmc_pwr_t PWR_CTL,
	output logic ED_PULSE,
	output logic INT_RST
);
	localparam int unsigned NPHY = swpmc_pkg::NPHY;

	swpmc_pkg::swpmc_state_t st_q;
	swpmc_pkg::swpmc_state_t st_d;
	swpmc_pkg::swpmc_pwr_t pwr_q;
	swpmc_pkg::swpmc_pwr_t pwr_d;
	logic [1:0] mode_q;
	logic [1:0] mode_pend_q;
	logic [7:0] sleep_q;
	logic [NPHY-1:0] pctl_pd_q;
	logic [NPHY-1:0] phyc_pd_q;
	logic [8:0] idle_cnt_q;
	logic soft_rst_q;
	logic ped_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [swpmc_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	// Word index from a byte address, shared by both channels
	function automatic logic [5:0] reg_index(input logic [swpmc_pkg::ADDR_W-1:0] addr);
		reg_index = addr[swpmc_pkg::ADDR_W-1:2];
	endfunction : reg_index

	// Whether an index names a mapped register
	function automatic logic reg_mapped(input logic [5:0] idx);
		reg_mapped = (idx == swpmc_pkg::IDX_MODE) || (idx == swpmc_pkg::IDX_SLEEP) ||
			(idx == swpmc_pkg::IDX_PCTL0) || (idx == swpmc_pkg::IDX_PCTL1) ||
			(idx == swpmc_pkg::IDX_PHYC0) || (idx == swpmc_pkg::IDX_PHYC1) ||
			(idx == swpmc_pkg::IDX_STATUS);
	endfunction : reg_mapped

	// Host access qualifiers; the bus is closed while host power is off
	logic host_on;
	logic wake;
	logic do_write;
	logic b_done;
	logic ar_take;
	logic [5:0] widx;
	logic [5:0] ridx;
	assign host_on = (st_q != swpmc_pkg::ST_ED_LOW) && (st_q != swpmc_pkg::ST_SOFT_PD);
	assign wake = (st_q == swpmc_pkg::ST_SOFT_PD) && (S_AXI_AWVALID || S_AXI_ARVALID);
	assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
	assign b_done = bvalid_q && S_AXI_BREADY;
	assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
	assign widx = reg_index(awaddr_q);
	assign ridx = reg_index(S_AXI_ARADDR);

	// Handshake outputs
	assign S_AXI_AWREADY = host_on && !aw_hold_q;
	assign S_AXI_WREADY = host_on && !w_hold_q;
	assign S_AXI_ARREADY = host_on && !rvalid_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RRESP = rresp_q;
	assign S_AXI_RDATA = rdata_q;
	assign PWR_CTL = pwr_q;
	assign ED_PULSE = ped_q;
	assign INT_RST = soft_rst_q;

	// Address and data latch in either order, one write outstanding
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_hold_q <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold_q <= 1'b1;
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end else if (do_write) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Write response, one cycle after both halves are in
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			bvalid_q <= 1'b0;
			bresp_q <= swpmc_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= reg_mapped(widx) && (widx != swpmc_pkg::IDX_STATUS) ?
				swpmc_pkg::RESP_OKAY : swpmc_pkg::RESP_SLVERR;
		end else if (b_done) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data mux, status shows live state and line energy
	logic [31:0] rd_word;
	assign rd_word =
		(ridx == swpmc_pkg::IDX_MODE) ? 32'(mode_q) << swpmc_pkg::MODE_LSB :
		(ridx == swpmc_pkg::IDX_SLEEP) ? 32'(sleep_q) :
		(ridx == swpmc_pkg::IDX_PCTL0) ? 32'(pctl_pd_q[0]) << swpmc_pkg::PCTL_PD_BIT :
		(ridx == swpmc_pkg::IDX_PCTL1) ? 32'(pctl_pd_q[1]) << swpmc_pkg::PCTL_PD_BIT :
		(ridx == swpmc_pkg::IDX_PHYC0) ? 32'(phyc_pd_q[0]) << swpmc_pkg::PHYC_PD_BIT :
		(ridx == swpmc_pkg::IDX_PHYC1) ? 32'(phyc_pd_q[1]) << swpmc_pkg::PHYC_PD_BIT :
		(ridx == swpmc_pkg::IDX_STATUS) ? 32'({LINE_ENERGY, st_q}) : 32'h0;

	// Read channel, answer registered one cycle after the address
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			rvalid_q <= 1'b0;
			rresp_q <= swpmc_pkg::RESP_OKAY;
			rdata_q <= 32'h0;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q <= reg_mapped(ridx) ? swpmc_pkg::RESP_OKAY : swpmc_pkg::RESP_SLVERR;
			rdata_q <= rd_word;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// Byte lanes carrying each field
	logic wr_mode;
	logic wr_sleep;
	logic [NPHY-1:0] wr_pctl;
	logic [NPHY-1:0] wr_phyc;
	assign wr_mode = do_write && (widx == swpmc_pkg::IDX_MODE) && wstrb_q[0];
	assign wr_sleep = do_write && (widx == swpmc_pkg::IDX_SLEEP) && wstrb_q[0];
	assign wr_pctl[0] = do_write && (widx == swpmc_pkg::IDX_PCTL0) && wstrb_q[0];
	assign wr_pctl[1] = do_write && (widx == swpmc_pkg::IDX_PCTL1) && wstrb_q[0];
	assign wr_phyc[0] = do_write && (widx == swpmc_pkg::IDX_PHYC0) && wstrb_q[1];
	assign wr_phyc[1] = do_write && (widx == swpmc_pkg::IDX_PHYC1) && wstrb_q[1];

	// Config registers; a soft wake returns them to defaults
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_pend_q <= swpmc_pkg::MODE_NORMAL;
			mode_q <= swpmc_pkg::MODE_NORMAL;
			sleep_q <= swpmc_pkg::SLEEP_RST;
			pctl_pd_q <= '0;
			phyc_pd_q <= '0;
		end else if (wake) begin
			mode_pend_q <= swpmc_pkg::MODE_NORMAL;
			mode_q <= swpmc_pkg::MODE_NORMAL;
			sleep_q <= swpmc_pkg::SLEEP_RST;
			pctl_pd_q <= '0;
			phyc_pd_q <= '0;
		end else begin
			if (wr_mode) begin
				mode_pend_q <= wdata_q[swpmc_pkg::MODE_LSB +: 2];
			end
			// Held back until the response is taken, so the write is never cut off
			if (b_done) begin
				mode_q <= mode_pend_q;
			end
			if (wr_sleep) begin
				sleep_q <= wdata_q[7:0];
			end
			for (int i = 0; i < NPHY; i++) begin
				if (wr_pctl[i]) begin
					pctl_pd_q[i] <= wdata_q[swpmc_pkg::PCTL_PD_BIT];
				end
				if (wr_phyc[i]) begin
					phyc_pd_q[i] <= wdata_q[swpmc_pkg::PHYC_PD_BIT];
				end
			end
		end
	end

	// Timebases: sleep tick while awake in energy detect, beacon while low
	logic sleep_tick;
	logic beacon;
	swpmc_pulse_gen #(
		.PERIOD(SLEEP_TICK_CYC),
		.WIDTH(1)
	) u_sleep_tick (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.en(st_q == swpmc_pkg::ST_ED_AWAKE),
		.tick(sleep_tick),
		.pulse()
	);
	swpmc_pulse_gen #(
		.PERIOD(PULSE_PERIOD_CYC),
		.WIDTH(swpmc_pkg::ED_PULSE_CYC)
	) u_beacon (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.en(st_q == swpmc_pkg::ST_ED_LOW),
		.tick(),
		.pulse(beacon)
	);

	// Quiet-line timer; any energy restarts it
	logic line_idle;
	logic sleep_due;
	assign line_idle = ~|LINE_ENERGY;
	assign sleep_due = line_idle && (idle_cnt_q > {1'b0, sleep_q});
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			idle_cnt_q <= 9'h0;
		end else if (st_q != swpmc_pkg::ST_ED_AWAKE || !line_idle) begin
			idle_cnt_q <= 9'h0;
		end else if (sleep_tick && !idle_cnt_q[8]) begin
			idle_cnt_q <= idle_cnt_q + 9'h1;
		end
	end

	// Mode sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			swpmc_pkg::ST_NORMAL: begin
				if (mode_q == swpmc_pkg::MODE_ENERGY) begin
					st_d = swpmc_pkg::ST_ED_AWAKE;
				end else if (mode_q == swpmc_pkg::MODE_SOFTPD) begin
					st_d = swpmc_pkg::ST_SOFT_PD;
				end else if (mode_q == swpmc_pkg::MODE_SAVING && AUTONEG_EN && line_idle) begin
					st_d = swpmc_pkg::ST_SAVE;
				end
			end
			swpmc_pkg::ST_ED_AWAKE: begin
				if (mode_q != swpmc_pkg::MODE_ENERGY) begin
					st_d = swpmc_pkg::ST_NORMAL;
				end else if (sleep_due) begin
					st_d = swpmc_pkg::ST_ED_LOW;
				end
			end
			swpmc_pkg::ST_ED_LOW: begin
				if (!line_idle) begin
					st_d = swpmc_pkg::ST_ED_AWAKE;
				end
			end
			swpmc_pkg::ST_SOFT_PD: begin
				if (wake) begin
					st_d = swpmc_pkg::ST_NORMAL;
				end
			end
			swpmc_pkg::ST_SAVE: begin
				if (mode_q != swpmc_pkg::MODE_SAVING) begin
					st_d = swpmc_pkg::ST_NORMAL;
				end
			end
			default: st_d = swpmc_pkg::ST_NORMAL;
		endcase
	end

	// Gate decode; per-port power-down overrides every mode
	logic [NPHY-1:0] port_pd;
	logic full_on;
	assign port_pd = pctl_pd_q | phyc_pd_q;
	assign full_on = (st_q == swpmc_pkg::ST_NORMAL) || (st_q == swpmc_pkg::ST_ED_AWAKE);
	always_comb begin
		pwr_d.pll_en = full_on || (st_q == swpmc_pkg::ST_SAVE);
		pwr_d.mac_en = full_on || (st_q == swpmc_pkg::ST_SAVE);
		pwr_d.host_en = host_on;
		for (int i = 0; i < NPHY; i++) begin
			pwr_d.phy_tx_en[i] = !port_pd[i] && (full_on || st_q == swpmc_pkg::ST_SAVE);
			pwr_d.phy_rx_en[i] = !port_pd[i] && (full_on ||
				(st_q == swpmc_pkg::ST_SAVE && LINE_ENERGY[i]));
			pwr_d.phy_ed_en[i] = !port_pd[i] && (st_q == swpmc_pkg::ST_ED_LOW);
		end
	end

	// State, gates, beacon and internal reset pulse
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q <= swpmc_pkg::ST_NORMAL;
			pwr_q <= '0;
			ped_q <= 1'b0;
			soft_rst_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pwr_q <= pwr_d;
			ped_q <= beacon;
			soft_rst_q <= wake;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	// Helper: length of the current beacon pulse
	logic [7:0] plen_q;
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			plen_q <= 8'h0;
		end else begin
			plen_q <= ped_q ? plen_q + 8'h1 : 8'h0;
		end
	end

	sequence s_wake_seen;
		wake;
	endsequence
	sequence s_back_normal;
		##1 (st_q == swpmc_pkg::ST_NORMAL && mode_q == swpmc_pkg::MODE_NORMAL && soft_rst_q);
	endsequence

	soft_wake_a: assert property (s_wake_seen |-> s_back_normal)
		else $error("soft power-down wake did not reset to normal");
	normal_gates_a: assert property (!SYS_RST && st_q == swpmc_pkg::ST_NORMAL |=> pwr_q.pll_en && pwr_q.mac_en && pwr_q.host_en)
		else $error("normal mode gates not all on");
	ed_enter_a: assert property (st_q == swpmc_pkg::ST_NORMAL && mode_q == swpmc_pkg::MODE_ENERGY
		|=> st_q == swpmc_pkg::ST_ED_AWAKE)
		else $error("energy detect mode not entered");
	sleep_entry_a: assert property (st_q == swpmc_pkg::ST_ED_AWAKE && mode_q == swpmc_pkg::MODE_ENERGY
		&& line_idle && idle_cnt_q > {1'b0, sleep_q} |=> st_q == swpmc_pkg::ST_ED_LOW)
		else $error("low power state not entered after quiet time");
	low_gates_a: assert property (st_q == swpmc_pkg::ST_ED_LOW |-> !S_AXI_ARREADY ##1 (!pwr_q.pll_en && !pwr_q.mac_en
		&& !pwr_q.host_en && pwr_q.phy_tx_en == '0))
		else $error("circuitry left on in low power state");
	beacon_len_a: assert property ($fell(ped_q) && $past(st_q, 2) == swpmc_pkg::ST_ED_LOW
		&& $past(st_q) == swpmc_pkg::ST_ED_LOW |-> plen_q == 8'(swpmc_pkg::ED_PULSE_CYC))
		else $error("beacon pulse width not 12 cycles");
	energy_wake_a: assert property (st_q == swpmc_pkg::ST_ED_LOW && !line_idle |=> st_q == swpmc_pkg::ST_ED_AWAKE)
		else $error("energy did not wake the low power state");
	softpd_enter_a: assert property (st_q == swpmc_pkg::ST_NORMAL && mode_q == swpmc_pkg::MODE_SOFTPD
		|=> st_q == swpmc_pkg::ST_SOFT_PD ##1 (!pwr_q.pll_en && !pwr_q.mac_en && pwr_q.phy_rx_en == '0))
		else $error("soft power-down not applied");
	save_enter_a: assert property (st_q == swpmc_pkg::ST_NORMAL && mode_q == swpmc_pkg::MODE_SAVING
		&& AUTONEG_EN && line_idle |=> st_q == swpmc_pkg::ST_SAVE ##1 (pwr_q.pll_en && pwr_q.mac_en && pwr_q.host_en))
		else $error("power saving not entered or gates wrong");
	save_rx_a: assert property (st_q == swpmc_pkg::ST_SAVE && !port_pd[0]
		|=> pwr_q.phy_tx_en[0] && pwr_q.phy_rx_en[0] == $past(LINE_ENERGY[0]))
		else $error("power saving receiver gating wrong");
	save_exit_a: assert property (st_q == swpmc_pkg::ST_SAVE && mode_q != swpmc_pkg::MODE_SAVING
		|=> st_q == swpmc_pkg::ST_NORMAL)
		else $error("power saving did not follow mode write");
	port_pd_a: assert property (port_pd[1] |=> !pwr_q.phy_tx_en[1] && !pwr_q.phy_rx_en[1])
		else $error("powered-down port still enabled");
	mode_commit_a: assert property ($changed(mode_q) |-> $past(b_done) || $past(wake))
		else $error("mode changed before write completed");
endmodule : swpmc_top

/* testbench/swpmc_host_bfm.sv */
// Host processor model on the register bus
`timescale 1ns/1ns
module swpmc_host_bfm (
	input wire logic clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// Idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Write: address and data offered together; released payload is inverted so it never looks current
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic aw_p;
		logic w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge clk);
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} <= {a, 1'b1, d, s, 1'b1, 1'b1};
		while (aw_p || w_p) begin
			@(posedge clk);
			if (aw_p && awready === 1'b1) begin
				aw_p = 1'b0;
				{awaddr, awvalid} <= {~a, 1'b0};
			end
			if (w_p && wready === 1'b1) begin
				w_p = 1'b0;
				{wdata, wstrb, wvalid} <= {~d, ~s, 1'b0};
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	// Read: address held until taken, answer taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
		do @(posedge clk); while (arready !== 1'b1);
		{araddr, arvalid} <= {~a, 1'b0};
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : swpmc_host_bfm

/* testbench/tb_top.sv */
// Self-checking bench of the power mode controller
`timescale 1ns/1ns
module tb_top;
	localparam int unsigned PERIOD = 64;
	localparam int unsigned TICK = 4;
	localparam logic [1:0] OK = swpmc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = swpmc_pkg::RESP_SLVERR;
	localparam logic [7:0] A_MODE = {swpmc_pkg::IDX_MODE, 2'b00};
	localparam logic [7:0] A_SLEEP = {swpmc_pkg::IDX_SLEEP, 2'b00};
	localparam logic [7:0] A_STAT = {swpmc_pkg::IDX_STATUS, 2'b00};
	logic clk_sys, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, autoneg_en, ed_pulse, int_rst;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, line_energy;
	swpmc_pkg::swpmc_pwr_t pwr;
	int error_cnt = 0;
	int check_count = 0;
	int rst_seen = 0;

	swpmc_top #(.PULSE_PERIOD_CYC(PERIOD), .SLEEP_TICK_CYC(TICK)) uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .LINE_ENERGY(line_energy), .AUTONEG_EN(autoneg_en), .PWR_CTL(pwr),
		.ED_PULSE(ed_pulse), .INT_RST(int_rst));

	swpmc_host_bfm host (.clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	// Clock and count of internal reset pulses
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (int_rst === 1'b1) rst_seen++;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cyc

	// Cycles until the beacon reaches a level; bounded so a dead beacon cannot hang
	task automatic wait_lvl(input logic lvl, output int n);
		n = 0;
		while (ed_pulse !== lvl && n < 200) begin
			wait_cyc(1);
			n++;
		end
	endtask : wait_lvl

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		check(d & m, e);
		check({30'h0, r}, {30'h0, er});
	endtask : rd_chk

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		host.wr(a, d, 4'hf, r);
		check({30'h0, r}, {30'h0, OK});
	endtask : wr_ok

	// Full power with the given ports shut off
	function automatic logic [8:0] exp_norm(input logic [1:0] pd);
		return {3'b111, ~pd, ~pd, 2'b00};
	endfunction : exp_norm

	// Watchdog; the tests need a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		stop_test();
	end

	initial begin
		logic [7:0] sl;
		logic [1:0] pd, sel, r;
		int n, w;
		sys_rst = 1'b1;
		line_energy = 2'b00;
		autoneg_en = 1'b0;
		void'($urandom(32'h3895b06b));
		wait_cyc(2);
		check(32'(pwr), 32'h0);
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wait_cyc(1);
		check(32'(pwr), 32'(exp_norm(2'b00)));
		rd_chk(A_MODE, 32'h18, 32'h0, OK);
		rd_chk(8'hfc, 32'hffffffff, 32'h0, ERR);
		host.wr(A_STAT, 32'h7, 4'hf, r);
		check({30'h0, r}, {30'h0, ERR});
		$display("test reset done");

		// Random per-port shutdown through either control bit
		for (int i = 0; i < 6; i++) begin
			pd = 2'($urandom);
			sel = 2'($urandom);
			for (int p = 0; p < 2; p++) begin
				wr_ok({swpmc_pkg::IDX_PCTL0 + 6'(p), 2'b00}, (pd[p] & sel[p]) ? 32'h8 : 32'h0);
				wr_ok({swpmc_pkg::IDX_PHYC0 + 6'(p), 2'b00}, (pd[p] & ~sel[p]) ? 32'h800 : 32'h0);
			end
			wait_cyc(2);
			check(32'(pwr), 32'(exp_norm(pd)));
		end
		wr_ok({swpmc_pkg::IDX_PCTL0, 2'b00}, 32'h0);
		wr_ok({swpmc_pkg::IDX_PCTL0 + 6'd1, 2'b00}, 32'h0);
		wr_ok({swpmc_pkg::IDX_PHYC0, 2'b00}, 32'h0);
		wr_ok({swpmc_pkg::IDX_PHYC0 + 6'd1, 2'b00}, 32'h0);
		$display("test port_down done");

		// Energy detect: awake while energy shows, low power after the quiet time
		sl = 8'(1 + $urandom_range(2));
		wr_ok(A_SLEEP, {24'h0, sl});
		@(posedge clk_sys);
		line_energy <= 2'b01;
		wr_ok(A_MODE, 32'h8);
		wait_cyc(40);
		rd_chk(A_STAT, 32'h7, 32'h1, OK);
		@(posedge clk_sys);
		line_energy <= 2'b00;
		n = 0;
		while (pwr.pll_en !== 1'b0 && n < 400) begin
			wait_cyc(1);
			n++;
		end
		check(32'(n > sl * TICK && n <= (sl + 2) * TICK + 4), 32'h1);
		check(32'(pwr), 32'h3);
		check({31'h0, arready}, 32'h0);
		wait_lvl(1'b1, n);
		wait_lvl(1'b0, w);
		check(w, swpmc_pkg::ED_PULSE_CYC);
		wait_lvl(1'b1, n);
		check(w + n, PERIOD);
		@(posedge clk_sys);
		line_energy <= 2'b10;
		wait_cyc(2);
		check(32'(pwr), 32'(exp_norm(2'b00)));
		rd_chk(A_STAT, 32'h7, 32'h1, OK);
		wr_ok(A_MODE, 32'h0);
		@(posedge clk_sys);
		line_energy <= 2'b00;
		$display("test energy_detect done");

		// Soft power-down, then a dummy read wakes and resets the registers
		wr_ok(A_MODE, 32'h10);
		wait_cyc(3);
		check(32'(pwr), 32'h0);
		check({31'h0, awready}, 32'h0);
		rst_seen = 0;
		rd_chk(A_MODE, 32'h18, 32'h0, OK);
		check(rst_seen, 1);
		rd_chk(A_SLEEP, 32'hff, {24'h0, swpmc_pkg::SLEEP_RST}, OK);
		check(32'(pwr), 32'(exp_norm(2'b00)));
		$display("test soft_down done");

		// Power saving needs auto-negotiation; receivers follow the line
		wr_ok(A_MODE, 32'h18);
		wait_cyc(3);
		rd_chk(A_STAT, 32'h7, 32'h0, OK);
		@(posedge clk_sys);
		autoneg_en <= 1'b1;
		wr_ok(A_SLEEP, 32'h5a);
		wait_cyc(3);
		rd_chk(A_STAT, 32'h7, 32'h4, OK);
		rd_chk(A_SLEEP, 32'hff, 32'h5a, OK);
		check(32'(pwr[8:2]), 32'h7c);
		@(posedge clk_sys);
		line_energy <= 2'b01;
		wait_cyc(2);
		check(32'(pwr.phy_rx_en), 32'h1);
		wr_ok(A_MODE, 32'h0);
		wait_cyc(3);
		rd_chk(A_STAT, 32'h7, 32'h0, OK);
		$display("test power_saving done");
		stop_test();
	end
endmodule : tb_top
